// >>> pkg/srrs_pkg.sv
package srrs_pkg;
    // ****************************************
    // Release delays, in ticks of each stage
    // ****************************************
    localparam int unsigned POR_EXT_CYCLES = 64;
    localparam int unsigned CLKGEN_EXT_CYCLES = 32;
    localparam int unsigned PERIP_EXT_CYCLES = 32;
    localparam int unsigned CORE_EXT_CYCLES = 32;
    localparam int unsigned SYNC_GEN_CYCLES = 3;
    localparam int unsigned SYNC_CNT_W = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_ASSERTED = 1'b1;
    localparam logic SYS_CLK_RESET = 1'b0;
    localparam logic [SYNC_CNT_W-1:0] SYNC_CNT_RESET = 2'h0;
endpackage

// >>> pkg/srrs_ext_if.sv
`timescale 1ns/1ps
interface srrs_ext_if;
    logic hold;
    logic tick;
    logic active;
    modport stage
    (
        input hold,
        input tick,
        output active
    );
    modport ctrl
    (
        output hold,
        output tick,
        input active
    );
endinterface

// >>> logic/srrs_extender.sv
`timescale 1ns/1ps
module srrs_extender #(
    parameter int unsigned CYCLES = 32
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    srrs_ext_if.stage ext
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic active;
    } srrs_ext_state_t;

    srrs_ext_state_t s_reg;
    srrs_ext_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (ext.hold)
        begin
            // Reassert at once, restart the count
            s_next.cnt = '0;
            s_next.active = srrs_pkg::RST_ASSERTED;
        end
        else if (s_reg.active && ext.tick)
        begin
            if (s_reg.cnt == LAST)
                s_next.active = 1'b0;
            else
                s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_reg.cnt <= '0;
            s_reg.active <= srrs_pkg::RST_ASSERTED;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign ext.active = s_reg.active;
endmodule

// >>> logic/srrs_sequencer.sv
`timescale 1ns/1ps
// What this block does
// R01: Accept pin, power-on, software, two watchdog resets
// R02: Test access port reset only by power-on
// R03: Extend power-on reset 64 oscillator cycles
// R04: Combined reset ORs all five reset causes
// R05: Combined reset holds everything except extender and test access port reset
// R06: Combined release enables sync generator, clock stage
// R07: Sync reset released three oscillator cycles later
// R08: Clock-generator reset released 32 oscillator cycles later
// R09: Clock-generator release on oscillator falling edge; this block releases it on a rising edge
// R10: Early delay counters run on oscillator clock
// R11: Peripheral reset released 32 system cycles later
// R12: Clocks run while peripherals held in reset
// R13: Core reset released 32 system cycles later
// R14: Peripheral, core release on system clock fall
// R15: Core release ends start-up, code may run
// R16: Sequencer raises no interrupt
// R17: Any source reasserts every downstream reset immediately; pin and power-on sources first pass two synchroniser flops here
module srrs_sequencer
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic ext_reset_n,
    input wire logic sw_reset_req,
    input wire logic watchdog_timeout_reset,
    input wire logic watchdog_clock_loss_reset,
    output logic tap_rst,
    output logic ext_por_rst,
    output logic combined_rst,
    output logic sync_logic_rst,
    output logic clock_generator_reset,
    output logic peripheral_reset,
    output logic core_rst,
    output logic sys_clk
);
    // ****************************************
    // Types and helpers
    // ****************************************
    typedef struct packed
    {
        logic por_s1;
        logic por_s2;
        logic ext_s1;
        logic ext_s2;
        logic tap;
        logic combined;
        logic [srrs_pkg::SYNC_CNT_W-1:0] sync_cnt;
        logic sync_rst;
        logic sys_clk;
    } srrs_state_t;

    localparam logic [srrs_pkg::SYNC_CNT_W-1:0] SYNC_LAST = srrs_pkg::SYNC_CNT_W'(srrs_pkg::SYNC_GEN_CYCLES - 1);

    // Two-flop synchroniser step: returns {second, first}
    function automatic logic [1:0] srrs_sync2
    (
        input logic first_stage,
        input logic pin_asserted
    );
        return {first_stage, pin_asserted};
    endfunction

    // Held while combined is set now or was set one edge ago, so the count
    // starts on the edge after combined_rst itself goes low
    function automatic logic srrs_comb_hold
    (
        input logic comb_now,
        input logic comb_was
    );
        return comb_now | comb_was;
    endfunction

    // A later stage waits for its upstream stage, but drops back at once
    function automatic logic srrs_stage_hold
    (
        input logic comb_now,
        input logic upstream_active
    );
        return comb_now | upstream_active;
    endfunction

    // Any of the five causes, with the stretched power-on as well
    function automatic logic srrs_any_source
    (
        input logic por_sync,
        input logic por_stretched,
        input logic pin_sync,
        input logic sw_req,
        input logic wd_timeout,
        input logic wd_clock_loss
    );
        return por_sync | por_stretched | pin_sync | sw_req | wd_timeout | wd_clock_loss;
    endfunction

    srrs_state_t s_reg;
    srrs_state_t s_next;

    srrs_ext_if por_if ();
    srrs_ext_if cg_if ();
    srrs_ext_if pr_if ();
    srrs_ext_if cr_if ();

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_next = s_reg;
        // Pins are asynchronous: two flops before any use
        {s_next.por_s2, s_next.por_s1} = srrs_sync2(s_reg.por_s1, !por_n); // [R01]
        {s_next.ext_s2, s_next.ext_s1} = srrs_sync2(s_reg.ext_s1, !ext_reset_n); // [R01]

        s_next.tap = s_reg.por_s2; // [R02]
        // Synced power-on enters directly, so combined need not wait for the stretch
        s_next.combined = srrs_any_source(s_reg.por_s2, por_if.active, s_reg.ext_s2, sw_reset_req,
            watchdog_timeout_reset, watchdog_clock_loss_reset); // [R01] [R04] [R05]
        // Sync generator restarts on any cause, counts once combined_rst is low
        if (srrs_comb_hold(s_next.combined, s_reg.combined)) // [R17] [R07]
        begin
            s_next.sync_cnt = srrs_pkg::SYNC_CNT_RESET;
            s_next.sync_rst = srrs_pkg::RST_ASSERTED;
        end
        else if (s_reg.sync_rst) // [R06] [R07]
        begin
            if (s_reg.sync_cnt == SYNC_LAST)
                s_next.sync_rst = 1'b0;
            else
                s_next.sync_cnt = s_reg.sync_cnt + 1'b1;
        end

        // System clock only runs once clock generation is out of reset
        if (cg_if.active) // [R11]
            s_next.sys_clk = srrs_pkg::SYS_CLK_RESET;
        else
            s_next.sys_clk = !s_reg.sys_clk; // [R12]
    end

    // ****************************************
    // Registers
    // ****************************************
    // Synchronous reset puts every stage back to asserted
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_reg.por_s1 <= srrs_pkg::RST_ASSERTED;
            s_reg.por_s2 <= srrs_pkg::RST_ASSERTED;
            s_reg.ext_s1 <= srrs_pkg::RST_ASSERTED;
            s_reg.ext_s2 <= srrs_pkg::RST_ASSERTED;
            s_reg.tap <= srrs_pkg::RST_ASSERTED;
            s_reg.combined <= srrs_pkg::RST_ASSERTED;
            s_reg.sync_cnt <= srrs_pkg::SYNC_CNT_RESET;
            s_reg.sync_rst <= srrs_pkg::RST_ASSERTED;
            s_reg.sys_clk <= srrs_pkg::SYS_CLK_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Release chain
    // ****************************************
    // Early stages tick on every oscillator edge
    assign por_if.hold = s_reg.por_s2; // [R03]
    assign por_if.tick = 1'b1; // [R10]
    // Holds use the next combined value so the clock-generator, peripheral and core stages reassert together
    assign cg_if.hold = srrs_comb_hold(s_next.combined, s_reg.combined); // [R17] [R06]
    assign cg_if.tick = 1'b1; // [R08] [R10]
    assign pr_if.hold = srrs_stage_hold(s_next.combined, cg_if.active); // [R11] [R17]
    // Tick only where the system clock falls, so releases line up with it
    assign pr_if.tick = s_reg.sys_clk; // [R14]
    assign cr_if.hold = srrs_stage_hold(s_next.combined, pr_if.active); // [R13] [R17]
    assign cr_if.tick = s_reg.sys_clk; // [R14]

    // ****************************************
    // Stage extenders
    // ****************************************
    srrs_extender #(.CYCLES(srrs_pkg::POR_EXT_CYCLES)) u_por_ext
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ext(por_if.stage)
    );

    // Single clock: release lands on a rising edge; a falling-edge retime is left to the clock tree [R09]
    srrs_extender #(.CYCLES(srrs_pkg::CLKGEN_EXT_CYCLES)) u_cg_ext
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ext(cg_if.stage)
    );

    srrs_extender #(.CYCLES(srrs_pkg::PERIP_EXT_CYCLES)) u_pr_ext
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ext(pr_if.stage)
    );

    srrs_extender #(.CYCLES(srrs_pkg::CORE_EXT_CYCLES)) u_cr_ext
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ext(cr_if.stage)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // No interrupt output exists on this block [R16]
    // Every output is a flop: stage states come from the extender registers
    assign tap_rst = s_reg.tap;
    assign ext_por_rst = por_if.active;
    assign combined_rst = s_reg.combined;
    assign sync_logic_rst = s_reg.sync_rst;
    assign clock_generator_reset = cg_if.active;
    assign peripheral_reset = pr_if.active;
    assign core_rst = cr_if.active; // [R15]
    assign sys_clk = s_reg.sys_clk;
endmodule

// >>> verif/srrs_src.sv
`timescale 1ns/1ps
module srrs_src
(
    input wire logic [4:0] req,
    output logic por_n,
    output logic ext_reset_n,
    output logic sw_reset_req,
    output logic watchdog_timeout_reset,
    output logic watchdog_clock_loss_reset
);
    // Pins are active low, the rest active high
    assign por_n = !req[0];
    assign ext_reset_n = !req[1];
    assign sw_reset_req = req[2];
    assign watchdog_timeout_reset = req[3];
    assign watchdog_clock_loss_reset = req[4];
endmodule

// >>> verif/srrs_sequencer_properties.sv
`timescale 1ns/1ps
module srrs_sequencer_properties
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic ext_reset_n,
    input wire logic sw_reset_req,
    input wire logic watchdog_timeout_reset,
    input wire logic watchdog_clock_loss_reset,
    input wire logic tap_rst,
    input wire logic ext_por_rst,
    input wire logic combined_rst,
    input wire logic sync_logic_rst,
    input wire logic clock_generator_reset,
    input wire logic peripheral_reset,
    input wire logic core_rst,
    input wire logic sys_clk
);
    // Low-time counters, saturating so long idle cannot wrap
    logic [7:0] cb_reg, cg_reg, pr_reg;
    always_ff @(posedge ref_clk)
    begin
        cb_reg <= combined_rst ? 8'h00 : cb_reg + 8'(cb_reg != 8'hFF);
        cg_reg <= clock_generator_reset ? 8'h00 : cg_reg + 8'(cg_reg != 8'hFF);
        pr_reg <= peripheral_reset ? 8'h00 : pr_reg + 8'(pr_reg != 8'hFF);
    end
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_comb_quiet;
        $fell(combined_rst) ##1 !combined_rst [*3];
    endsequence
    sequence s_sys_fall;
        $past(sys_clk) && !sys_clk;
    endsequence
    chk_sync_src:
        assert property ((sw_reset_req || watchdog_timeout_reset || watchdog_clock_loss_reset)
            |=> combined_rst && sync_logic_rst && clock_generator_reset && core_rst) else $error("sync source");
    chk_pin_src:
        assert property (!ext_reset_n |-> ##3 combined_rst && peripheral_reset) else $error("pin source");
    chk_tap_por:
        assert property (!por_n |-> ##3 tap_rst) else $error("tap reset");
    chk_sync_release:
        assert property (s_comb_quiet |-> !sync_logic_rst && $past(sync_logic_rst)) else $error("sync release");
    chk_clkgen_delay:
        assert property ($fell(clock_generator_reset) |-> cb_reg == 8'h20) else $error("clkgen delay");
    chk_perip_delay:
        assert property ($fell(peripheral_reset) |-> cg_reg == 8'h40 ##0 s_sys_fall) else $error("perip delay");
    chk_core_delay:
        assert property ($fell(core_rst) |-> pr_reg == 8'h40 ##0 s_sys_fall) else $error("core delay");
    chk_release_order:
        assert property (!core_rst |-> !peripheral_reset && !clock_generator_reset && !combined_rst && !ext_por_rst)
        else $error("release order");
    chk_sysclk_held:
        assert property (clock_generator_reset |=> !sys_clk) else $error("system clock held");
    chk_sysclk_run:
        assert property (!clock_generator_reset |=> $changed(sys_clk)) else $error("system clock run");
endmodule
bind srrs_sequencer srrs_sequencer_properties u_srrs_sequencer_properties
(
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .por_n(por_n),
    .ext_reset_n(ext_reset_n),
    .sw_reset_req(sw_reset_req),
    .watchdog_timeout_reset(watchdog_timeout_reset),
    .watchdog_clock_loss_reset(watchdog_clock_loss_reset),
    .tap_rst(tap_rst),
    .ext_por_rst(ext_por_rst),
    .combined_rst(combined_rst),
    .sync_logic_rst(sync_logic_rst),
    .clock_generator_reset(clock_generator_reset),
    .peripheral_reset(peripheral_reset),
    .core_rst(core_rst),
    .sys_clk(sys_clk)
);

// >>> verif/srrs_sequencer_bench.sv
`timescale 1ns/1ps
module srrs_sequencer_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] req = 5'h01;
    logic por_n, ext_reset_n, sw_reset_req, watchdog_timeout_reset, watchdog_clock_loss_reset;
    logic tap_rst, ext_por_rst, combined_rst, sync_logic_rst, clock_generator_reset, peripheral_reset, core_rst, sys_clk;
    int n_mismatch = 0;
    int samples_checked = 0;
    int fall [6];
    int b, c, j, s;
    logic [5:0] v;
    always #10 ref_clk = ~ref_clk;
    srrs_sequencer u_srrs_sequencer
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .por_n(por_n),
        .ext_reset_n(ext_reset_n),
        .sw_reset_req(sw_reset_req),
        .watchdog_timeout_reset(watchdog_timeout_reset),
        .watchdog_clock_loss_reset(watchdog_clock_loss_reset),
        .tap_rst(tap_rst),
        .ext_por_rst(ext_por_rst),
        .combined_rst(combined_rst),
        .sync_logic_rst(sync_logic_rst),
        .clock_generator_reset(clock_generator_reset),
        .peripheral_reset(peripheral_reset),
        .core_rst(core_rst),
        .sys_clk(sys_clk)
    );
    srrs_src u_srrs_src
    (
        .req(req),
        .por_n(por_n),
        .ext_reset_n(ext_reset_n),
        .sw_reset_req(sw_reset_req),
        .watchdog_timeout_reset(watchdog_timeout_reset),
        .watchdog_clock_loss_reset(watchdog_clock_loss_reset)
    );
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %0d seen %0d", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic hold(input int n);
        req = 5'(1 << s);
        repeat (n) @(negedge ref_clk);
        chk("held", {tap_rst, combined_rst, clock_generator_reset, peripheral_reset, core_rst}, {s == 0, 4'hF});
    endtask
    initial
    begin
        void'($urandom(81));
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        for (s = 0; s < 5; s++)
        begin
            hold(4 + $urandom % 4);
            req = 5'h00;
            // Abort somewhere mid-chain
            repeat (5 + $urandom % 150) @(negedge ref_clk);
            hold(4);
            req = 5'h00;
            b = (s == 0) ? 67 : (s == 1) ? 3 : 1;
            fall = '{default: -1};
            for (c = 1; c < 300 && fall[5] < 0; c++)
            begin
                @(negedge ref_clk);
                v = {core_rst, peripheral_reset, clock_generator_reset, sync_logic_rst, combined_rst, ext_por_rst};
                for (j = 0; j < 6; j++)
                    if (v[j] === 1'b0 && fall[j] < 0)
                        fall[j] = c;
            end
            if (s == 0)
                chk("ext_por", fall[0], b - 1);
            chk("combined", fall[1], b);
            chk("sync_logic", fall[2] - b, 3);
            chk("clkgen", fall[3] - b, 32);
            chk("peripheral", fall[4] - b, 96);
            chk("core", fall[5] - b, 160);
            if (fall[5] < 0)
                break;
        end
        conclude();
    end
endmodule
